// ---- core/table_read_and_data_memory.sv ----
`timescale 1ns/10ps
// How it works
// - Current-page table read address is PC page bits plus table pointer offset.
// - Last-page table read loads fetched word's upper part into table_high_byte.
// - table_high_byte is read-only; only table reads change it.
// - Every table read takes exactly two instruction cycles.
// - On the 1K program memory the last page begins at 300H.
// - Data memory is volatile 8-bit RAM of variant depth.
// - Special and general areas are consecutive, starting at 00H.
// - Every general purpose location is readable and writable.
// - Single-bit set and clear work on data memory locations.
// - Bank 0 reached directly; bank 1 only through indirect addressing.
// - Special function registers appear identically in both banks.
// - Unused special locations read as 00H.
// - Most special registers read/write; protected ones ignore writes.
// - Data memory reachable indirectly through the memory pointer.
// - Table read writes program word low byte to operand location.
// - table_high_byte bits beyond the program word read as 0.
// - Last-page read forces high address bits to 1, low from pointer.
module table_read_and_data_memory
    import tblmem_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input req_s req,
    input wire logic bank_sel,
    input wire logic [PROG_AW-9:0] pc_page,
    input wire logic [PROG_DW-1:0] pm_rdata,
    output logic req_ready,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic [PROG_AW-1:0] pm_addr,
    output logic pm_req,
    output logic [DATA_W-1:0] table_high_byte
);

    core_s st_r;
    core_s st_nxt;
    logic ram_we;
    logic [RAM_AW-1:0] ram_waddr;
    logic [DATA_W-1:0] ram_wdata;
    logic [RAM_AW-1:0] ram_raddr;
    logic [DATA_W-1:0] ram_rdata;
    logic [ADDR_W-1:0] eff_addr;
    logic eff_bank;
    logic [DATA_W-1:0] cur_val;
    wire logic [DATA_W-1:0] new_val;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_bank;
    logic wr_en;
    logic rd_is_gp;
    logic wr_is_gp;
    logic wr_is_mp;
    logic wr_is_tblp;

    gp_ram u_ram (
        .sys_clk(sys_clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    // Operand location: indirect through pointer, else bank 0
    always_comb begin
        if (req.addr == IND_ADDR) begin
            eff_addr = st_r.mp[ADDR_W-1:0];
            eff_bank = bank_sel;
        end else begin
            eff_addr = req.addr;
            eff_bank = 1'b0;
        end
    end

    assign ram_raddr = {eff_bank, eff_addr[RAM_AW-2:0]};
    assign rd_is_gp = (eff_addr >= GP_BASE);

    // Read value seen at the operand
    always_comb begin
        if (rd_is_gp) begin
            cur_val = ram_rdata;
        end else begin
            unique case (eff_addr)
                MP_ADDR: cur_val = st_r.mp;
                TBLP_ADDR: cur_val = st_r.tblp;
                THB_ADDR: cur_val = st_r.thb;
                default: cur_val = ZERO_BYTE;
            endcase
        end
    end

    // Bit operations, one lane per data bit
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_lane
        logic lane_hit;
        logic lane_set;
        logic lane_clr;
        assign lane_hit = (req.bit_idx == 3'(gi));
        assign lane_set = lane_hit | cur_val[gi];
        assign lane_clr = ~lane_hit & cur_val[gi];
        assign new_val[gi] = (req.op == OP_BSET) ? lane_set : ((req.op == OP_BCLR) ? lane_clr : req.wdata[gi]);
    end

    // Write port: table read result in its second cycle, else the operand
    always_comb begin
        wr_en = 1'b0;
        wr_addr = eff_addr;
        wr_bank = eff_bank;
        ram_wdata = new_val;
        if (st_r.state == ST_TBL) begin
            wr_en = 1'b1;
            wr_addr = st_r.dest;
            wr_bank = st_r.dest_bank;
            ram_wdata = pm_rdata[DATA_W-1:0];
        end else if (req.valid && (req.op inside {OP_WRITE, OP_BSET, OP_BCLR})) begin
            wr_en = 1'b1;
        end
    end

    // Write target decode; table_high_byte and indirect slot have no write path
    always_comb begin
        wr_is_gp = 1'b0;
        wr_is_mp = 1'b0;
        wr_is_tblp = 1'b0;
        if (wr_en) begin
            wr_is_gp = (wr_addr >= GP_BASE);
            wr_is_mp = (wr_addr == MP_ADDR);
            wr_is_tblp = (wr_addr == TBLP_ADDR);
        end
    end

    assign ram_we = wr_is_gp;
    assign ram_waddr = {wr_bank, wr_addr[RAM_AW-2:0]};

    // Sequencer: table reads take a fetch cycle and a write-back cycle
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.pm_req = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                if (req.valid) begin
                    unique case (req.op)
                        OP_READ: begin
                            st_nxt.rdata = cur_val;
                            st_nxt.done = 1'b1;
                        end

                        OP_WRITE, OP_BSET, OP_BCLR: begin
                            st_nxt.done = 1'b1;
                        end

                        OP_TRD_CUR: begin
                            st_nxt.pm_addr = {pc_page, st_r.tblp};
                            st_nxt.pm_req = 1'b1;
                            st_nxt.dest = eff_addr;
                            st_nxt.dest_bank = eff_bank;
                            st_nxt.ready = 1'b0;
                            st_nxt.state = ST_TBL;
                        end

                        OP_TRD_LAST: begin
                            st_nxt.pm_addr = LAST_PAGE_BASE | {2'h0, st_r.tblp};
                            st_nxt.pm_req = 1'b1;
                            st_nxt.dest = eff_addr;
                            st_nxt.dest_bank = eff_bank;
                            st_nxt.ready = 1'b0;
                            st_nxt.state = ST_TBL;
                        end

                        default: begin
                            st_nxt.rdata = ZERO_BYTE;
                        end
                    endcase
                end
            end

            ST_TBL: begin
                st_nxt.thb = {2'h0, pm_rdata[PROG_DW-1:DATA_W]};
                st_nxt.done = 1'b1;
                st_nxt.ready = 1'b1;
                st_nxt.state = ST_IDLE;
            end
        endcase

        if (wr_is_mp) begin
            st_nxt.mp = ram_wdata;
        end
        if (wr_is_tblp) begin
            st_nxt.tblp = ram_wdata;
        end
    end

    // State register; RAM contents are not cleared by reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.state <= ST_IDLE;
            st_r.ready <= 1'b1;
            st_r.done <= 1'b0;
            st_r.rdata <= ZERO_BYTE;
            st_r.mp <= MP_RST;
            st_r.tblp <= TBLP_RST;
            st_r.thb <= THB_RST;
            st_r.pm_addr <= PM_ADDR_RST;
            st_r.pm_req <= 1'b0;
            st_r.dest <= IND_ADDR;
            st_r.dest_bank <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_ready = st_r.ready;
    assign done = st_r.done;
    assign rdata = st_r.rdata;
    assign pm_addr = st_r.pm_addr;
    assign pm_req = st_r.pm_req;
    assign table_high_byte = st_r.thb;

endmodule

// ---- core/tblmem_pkg.sv ----
package tblmem_pkg;

    localparam int PROG_AW = 10;
    localparam int PROG_DW = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int RAM_AW = 6;

    localparam logic [ADDR_W-1:0] IND_ADDR = 6'h00;
    localparam logic [ADDR_W-1:0] MP_ADDR = 6'h01;
    localparam logic [ADDR_W-1:0] TBLP_ADDR = 6'h07;
    localparam logic [ADDR_W-1:0] THB_ADDR = 6'h08;
    localparam logic [ADDR_W-1:0] GP_BASE = 6'h20;

    localparam logic [PROG_AW-1:0] LAST_PAGE_BASE = 10'h300;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] MP_RST = 8'h00;
    localparam logic [DATA_W-1:0] TBLP_RST = 8'h00;
    localparam logic [DATA_W-1:0] THB_RST = 8'h00;
    localparam logic [PROG_AW-1:0] PM_ADDR_RST = 10'h000;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_BSET,
        OP_BCLR,
        OP_TRD_CUR,
        OP_TRD_LAST
    } op_e;

    typedef struct packed {
        logic valid;
        op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0] bit_idx;
    } req_s;

    typedef enum logic {
        ST_IDLE,
        ST_TBL
    } state_e;

    typedef struct packed {
        state_e state;
        logic ready;
        logic done;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] mp;
        logic [DATA_W-1:0] tblp;
        logic [DATA_W-1:0] thb;
        logic [PROG_AW-1:0] pm_addr;
        logic pm_req;
        logic [ADDR_W-1:0] dest;
        logic dest_bank;
    } core_s;

endpackage

// ---- core/gp_ram.sv ----
`timescale 1ns/10ps
module gp_ram
    import tblmem_pkg::*;
(
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [RAM_AW-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [RAM_AW-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule

// ---- dv/tblmem_sva.sv ----
`timescale 1ns/10ps
module tblmem_sva
    import tblmem_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input req_s req,
    input wire logic bank_sel,
    input wire logic [PROG_AW-9:0] pc_page,
    input wire logic [PROG_DW-1:0] pm_rdata,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [PROG_AW-1:0] pm_addr,
    input wire logic pm_req,
    input wire logic [DATA_W-1:0] table_high_byte
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic tbl;
    assign take = req.valid && req_ready;
    assign tbl = req.op inside {OP_TRD_CUR, OP_TRD_LAST};
    sequence fetch_s; pm_req && !req_ready && !done; endsequence
    sequence finish_s; done && req_ready && !pm_req; endsequence
    chk_tbl_walk: assert property (take && tbl |=> fetch_s ##1 finish_s)
        else $error("table read walk wrong");
    chk_last_page: assert property (take && req.op == OP_TRD_LAST |=> pm_addr[9:8] == 2'b11)
        else $error("last page address wrong");
    chk_cur_page: assert property (take && req.op == OP_TRD_CUR |=> pm_addr[9:8] == $past(pc_page))
        else $error("current page address wrong");
    chk_thb_load: assert property (pm_req |=> table_high_byte[5:0] == $past(pm_rdata[13:8]))
        else $error("high byte not loaded");
    chk_thb_upper: assert property (table_high_byte[7:6] == 2'b00)
        else $error("high byte upper bits set");
    chk_thb_hold: assert property (!pm_req |=> $stable(table_high_byte))
        else $error("high byte changed");
    chk_op_done: assert property (take && !tbl |=> done && req_ready)
        else $error("data op not done");
    chk_done_cause: assert property (done |-> $past(take) || $past(pm_req))
        else $error("spurious done");
    chk_fetch_pulse: assert property (pm_req |=> !pm_req)
        else $error("fetch strobe too long");
endmodule

// ---- dv/pm_model.sv ----
`timescale 1ns/10ps
module pm_model
    import tblmem_pkg::*;
(
    input wire logic [PROG_AW-1:0] pm_addr,
    input wire logic pm_req,
    output logic [PROG_DW-1:0] pm_rdata
);
    logic [PROG_DW-1:0] word;
    assign word = {pm_addr[9:4], pm_addr[7:0]};
    // Inverted word outside a fetch
    assign pm_rdata = pm_req ? word : ~word;
endmodule

// ---- dv/table_read_and_data_memory_tb.sv ----
`timescale 1ns/10ps
module table_read_and_data_memory_tb;
    import tblmem_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    req_s req = '0;
    logic bank_sel = 1'b0;
    logic [1:0] pc_page = 2'b00;
    logic [13:0] pm_rdata;
    logic req_ready, done, pm_req;
    logic [7:0] rdata, table_high_byte, got;
    logic [9:0] pm_addr;
    int failures = 0;
    int n_checks = 0;
    always #2 sys_clk = ~sys_clk;
    table_read_and_data_memory i_dut(.sys_clk, .rst_n, .req, .bank_sel, .pc_page, .pm_rdata,
        .req_ready, .done, .rdata, .pm_addr, .pm_req, .table_high_byte);
    pm_model i_pm(.pm_addr, .pm_req, .pm_rdata);
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic op(input op_e o, input logic [5:0] a, input logic [7:0] d = 8'h00, input logic [2:0] b = 3'h0);
        int n;
        n = 0;
        req <= '{1'b1, o, a, d, b};
        @(posedge sys_clk);
        req.valid <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("done", {7'h00, done}, 8'h01);
        got = rdata;
        @(posedge sys_clk);
    endtask
    task automatic t_ram();
        op(OP_WRITE, 6'h20, 8'hA5);
        op(OP_WRITE, 6'h3F, 8'h5A);
        op(OP_READ, 6'h20);
        check("gp_first", got, 8'hA5);
        op(OP_READ, 6'h3F);
        check("gp_last", got, 8'h5A);
        op(OP_WRITE, 6'h05, 8'hFF);
        op(OP_READ, 6'h05);
        check("unused", got, 8'h00);
        op(OP_WRITE, THB_ADDR, 8'hFF);
        op(OP_READ, THB_ADDR);
        check("thb_ro", got, 8'h00);
        $display("test ram done");
    endtask
    task automatic t_bank();
        bank_sel <= 1'b1;
        op(OP_WRITE, MP_ADDR, 8'h20);
        op(OP_WRITE, IND_ADDR, 8'h3C);
        op(OP_READ, 6'h20);
        check("direct_bank0", got, 8'hA5);
        op(OP_READ, IND_ADDR);
        check("indirect", got, 8'h3C);
        op(OP_WRITE, TBLP_ADDR, 8'h06);
        op(OP_WRITE, MP_ADDR, {2'b00, TBLP_ADDR});
        op(OP_READ, IND_ADDR);
        check("sfr_bank1", got, 8'h06);
        op(OP_WRITE, MP_ADDR, 8'h00);
        op(OP_WRITE, IND_ADDR, 8'h55);
        op(OP_READ, IND_ADDR);
        check("ind_self", got, 8'h00);
        bank_sel <= 1'b0;
        $display("test bank done");
    endtask
    task automatic t_bits();
        op(OP_WRITE, 6'h21, 8'h00);
        op(OP_BSET, 6'h21, 8'h00, 3'h7);
        op(OP_BSET, 6'h21, 8'h00, 3'h0);
        op(OP_BCLR, 6'h21, 8'h00, 3'h7);
        op(OP_READ, 6'h21);
        check("bits", got, 8'h01);
        $display("test bits done");
    endtask
    task automatic t_table();
        op(OP_TRD_LAST, 6'h22);
        check("thb_last", table_high_byte, 8'h30);
        op(OP_BCLR, THB_ADDR, 8'h00, 3'h4);
        check("thb_bit_ro", table_high_byte, 8'h30);
        op(OP_READ, 6'h22);
        check("low_last", got, 8'h06);
        op(OP_WRITE, TBLP_ADDR, 8'hFF);
        pc_page <= 2'b01;
        op(OP_TRD_CUR, 6'h23);
        check("thb_cur", table_high_byte, 8'h1F);
        op(OP_READ, 6'h23);
        check("low_cur", got, 8'hFF);
        $display("test table done");
    endtask
    task automatic t_reset();
        rst_n <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("rst_ready", {7'h00, req_ready}, 8'h01);
        check("rst_thb", table_high_byte, 8'h00);
        check("rst_rdata", rdata, 8'h00);
        check("rst_addr", pm_addr[7:0], 8'h00);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        op(OP_READ, TBLP_ADDR);
        check("rst_tblp", got, 8'h00);
        op(OP_TRD_LAST, 6'h24);
        check("thb_after_rst", table_high_byte, 8'h30);
        $display("test reset done");
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_ram();
        t_bank();
        t_bits();
        t_table();
        t_reset();
        print_verdict();
    end
    initial begin
        #8000;
        failures++;
        print_verdict();
    end
endmodule
bind table_read_and_data_memory tblmem_sva i_sva(.sys_clk, .rst_n, .req, .bank_sel, .pc_page, .pm_rdata,
    .req_ready, .done, .rdata, .pm_addr, .pm_req, .table_high_byte);
